// [hdl/hsc_pkg.sv]
package hsc_pkg;

  localparam int HSC_PC_W = 10;
  localparam logic [9:0] HSC_PC_RESET = 10'h000;
  localparam int HSC_TMR_W = 8;
  localparam int HSC_PRE_W = 4;
  localparam int HSC_MEM_W = 4;
  localparam int HSC_MEM_AW = 6;
  localparam int HSC_WAKE_BIT = 3;

  localparam logic [3:0] HSC_OP_CLEAR_ACC_HI = 4'hf;
  localparam logic [3:0] HSC_OP_CLEAR_ACC_LO = 4'hc;
  localparam logic [3:0] HSC_OP_LOAD_IMM_HI = 4'hc;
  localparam logic [7:0] HSC_OP_HALT = 8'hf6;

  typedef enum logic [1:0] {
    HSC_RUN,
    HSC_STANDBY
  } hsc_state_t;

  typedef enum logic [2:0] {
    HSC_OPC_OTHER,
    HSC_OPC_CLEAR_ACC,
    HSC_OPC_LOAD_IMM,
    HSC_OPC_HALT,
    HSC_OPC_ABSENT
  } hsc_opclass_t;

endpackage

// [hdl/hsc_data_mem.sv]
`timescale 1ns/1ps
module hsc_data_mem
  import hsc_pkg::*;
#(
  parameter int AW = HSC_MEM_AW,
  parameter int DW = HSC_MEM_W
) (
  // Clock.
  input wire logic clk,
  // Access port.
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_reg
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset here, so the contents survive a chip clear as real storage does.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_reg <= mem[addr];
  end

endmodule // hsc_data_mem

// [hdl/hsc_halt_standby_control.sv]
// Operation
// - In a run of clear-accumulator opcodes only the first executes, rest are no-ops.
// - In a run of load-immediate opcodes only the first executes, rest are no-ops.
// - Omitted family instructions are decoded as no-operations, never executed.
// - Halt enters standby only while the wake pin is high.
// - Low chip clear input ends standby.
// - Low wake pin ends standby.
// - Wake pin release only with the RC clock option; resonator needs reset.
// - Any reset clears the program counter to address zero.
// - Registers and data memory hold their contents during standby.
// - Chip clear while running behaves exactly as power-on reset.
`timescale 1ns/1ps
module hsc_halt_standby_control
  import hsc_pkg::*;
#(
  parameter int PC_W = HSC_PC_W
) (
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic nrst,
  // Pins.
  input wire logic chip_clear_pin_n,
  input wire logic [3:0] port_a,
  input wire logic osc_rc_option,
  // Instruction stream, one opcode per cycle.
  input wire logic [7:0] opcode,
  input wire logic op_valid,
  input wire logic mem_we,
  input wire logic [HSC_MEM_AW-1:0] mem_addr,
  // Status.
  output logic standby_reg,
  output logic [PC_W-1:0] program_counter_reg,
  output logic [3:0] acc_reg,
  output logic [HSC_TMR_W-1:0] timer_reg,
  output logic exec_strobe_reg,
  output logic [HSC_MEM_W-1:0] mem_rdata_reg
);

  hsc_state_t state_reg;
  hsc_opclass_t prev_class_reg;
  hsc_opclass_t op_class;
  logic [HSC_PRE_W-1:0] pre_reg;
  logic wake_pin;
  logic clear_n;
  logic exec_ok;

  function automatic hsc_opclass_t classify(input logic [7:0] op);
    if (op == HSC_OP_HALT) begin
      classify = HSC_OPC_HALT;
    end else if (op == {HSC_OP_CLEAR_ACC_HI, HSC_OP_CLEAR_ACC_LO}) begin
      classify = HSC_OPC_CLEAR_ACC;
    end else if (op[7:4] == HSC_OP_LOAD_IMM_HI) begin
      classify = HSC_OPC_LOAD_IMM;
    end else if (op[7:4] == 4'hd || op[7:4] == 4'h9) begin
      classify = HSC_OPC_ABSENT;
    end else begin
      classify = HSC_OPC_OTHER;
    end
  endfunction

  // The pin clear and the power-on reset share one path, so both behave the same.
  assign clear_n = nrst & chip_clear_pin_n;
  assign wake_pin = port_a[HSC_WAKE_BIT];
  assign op_class = classify(opcode);

  // A run is broken by any other instruction, so a repeat only counts back to back.
  always_comb begin
    exec_ok = op_valid && state_reg == HSC_RUN;
    if (op_class == HSC_OPC_CLEAR_ACC && prev_class_reg == HSC_OPC_CLEAR_ACC) begin
      exec_ok = 1'b0;
    end
    if (op_class == HSC_OPC_LOAD_IMM && prev_class_reg == HSC_OPC_LOAD_IMM) begin
      exec_ok = 1'b0;
    end
    if (op_class == HSC_OPC_ABSENT) begin
      exec_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge clear_n) begin
    if (!clear_n) begin
      state_reg <= HSC_RUN;
      standby_reg <= 1'b0;
    end else begin
      case (state_reg)
        HSC_RUN: begin
          if (op_valid && op_class == HSC_OPC_HALT && wake_pin) begin
            state_reg <= HSC_STANDBY;
            standby_reg <= 1'b1;
          end
        end
        HSC_STANDBY: begin
          if (!wake_pin && osc_rc_option) begin
            state_reg <= HSC_RUN;
            standby_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= HSC_RUN;
          standby_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge clear_n) begin
    if (!clear_n) begin
      prev_class_reg <= HSC_OPC_OTHER;
    end else if (op_valid && state_reg == HSC_RUN) begin
      prev_class_reg <= op_class;
    end
  end

  // The halt opcode itself advances the counter, so a wake resumes after it.
  always_ff @(posedge clk or negedge clear_n) begin
    if (!clear_n) begin
      program_counter_reg <= PC_W'(HSC_PC_RESET);
      exec_strobe_reg <= 1'b0;
    end else begin
      exec_strobe_reg <= exec_ok;
      if (op_valid && state_reg == HSC_RUN) begin
        program_counter_reg <= program_counter_reg + PC_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge clear_n) begin
    if (!clear_n) begin
      acc_reg <= 4'h0;
    end else if (exec_ok && op_class == HSC_OPC_CLEAR_ACC) begin
      acc_reg <= 4'h0;
    end else if (exec_ok && op_class == HSC_OPC_LOAD_IMM) begin
      acc_reg <= opcode[3:0];
    end
  end

  always_ff @(posedge clk or negedge clear_n) begin
    if (!clear_n) begin
      pre_reg <= '0;
      timer_reg <= '0;
    end else if (state_reg == HSC_RUN) begin
      pre_reg <= pre_reg + HSC_PRE_W'(1);
      if (&pre_reg) begin
        timer_reg <= timer_reg + HSC_TMR_W'(1);
      end
    end
  end

  // Writes are refused in standby so data memory stays as it was.
  hsc_data_mem #(
    .AW(HSC_MEM_AW),
    .DW(HSC_MEM_W)
  ) u_mem (
    .clk(clk),
    .we(mem_we && state_reg == HSC_RUN),
    .addr(mem_addr),
    .wdata(acc_reg),
    .rdata_reg(mem_rdata_reg)
  );

  // Halt entry and wake release are named once and reused, so the checks cannot drift apart.
  sequence s_halt_taken;
    state_reg == HSC_RUN && op_valid && op_class == HSC_OPC_HALT && wake_pin;
  endsequence

  sequence s_wake_release;
    standby_reg && !wake_pin && osc_rc_option;
  endsequence

  a_halt_enters: assert property (@(posedge clk) disable iff (!clear_n)
    s_halt_taken |=> standby_reg)
    else $error("halt with wake high did not enter standby");

  a_halt_steps_pc: assert property (@(posedge clk) disable iff (!clear_n)
    s_halt_taken |=> program_counter_reg == PC_W'($past(program_counter_reg) + 1'b1))
    else $error("halt did not advance the program counter");

  a_halt_low_stays: assert property (@(posedge clk) disable iff (!clear_n)
    (state_reg == HSC_RUN && !wake_pin) |=> !standby_reg)
    else $error("standby entered with wake pin low");

  a_wake_rc_release: assert property (@(posedge clk) disable iff (!clear_n)
    s_wake_release |=> !standby_reg)
    else $error("wake pin did not release standby");

  a_wake_keeps_pc: assert property (@(posedge clk) disable iff (!clear_n)
    s_wake_release |=> $stable(program_counter_reg))
    else $error("wake release moved the program counter");

  a_resonator_holds: assert property (@(posedge clk) disable iff (!clear_n)
    (standby_reg && !osc_rc_option) |=> standby_reg)
    else $error("standby left without reset on resonator");

  sequence s_clear_pair;
    op_valid && state_reg == HSC_RUN && op_class == HSC_OPC_CLEAR_ACC
      && prev_class_reg == HSC_OPC_CLEAR_ACC;
  endsequence

  a_repeat_clear: assert property (@(posedge clk) disable iff (!clear_n)
    s_clear_pair |=> !exec_strobe_reg)
    else $error("repeated clear executed");

  a_repeat_load: assert property (@(posedge clk) disable iff (!clear_n)
    (op_valid && op_class == HSC_OPC_LOAD_IMM && prev_class_reg == HSC_OPC_LOAD_IMM)
    |=> $stable(acc_reg))
    else $error("repeated load changed accumulator");

  a_absent_op: assert property (@(posedge clk) disable iff (!clear_n)
    (op_valid && op_class == HSC_OPC_ABSENT) |=> !exec_strobe_reg)
    else $error("omitted instruction executed");

  a_standby_frozen: assert property (@(posedge clk) disable iff (!clear_n)
    (standby_reg && $past(standby_reg)) |-> $stable(program_counter_reg)
      && $stable(timer_reg) && $stable(acc_reg))
    else $error("state advanced in standby");

  a_timer_ticks: assert property (@(posedge clk) disable iff (!clear_n)
    (state_reg == HSC_RUN && &pre_reg)
    |=> timer_reg == HSC_TMR_W'($past(timer_reg) + 1'b1))
    else $error("timer did not advance in run");

  a_reset_pc: assert property (@(posedge clk)
    !clear_n |-> program_counter_reg == HSC_PC_RESET)
    else $error("program counter not zero in reset");

endmodule // hsc_halt_standby_control

// [testbench/hsc_pwr_model.sv]
`timescale 1ns/1ps
module hsc_pwr_model (
  // Clock.
  input wire logic clk,
  // Commands from the bench.
  input wire logic power_fail,
  input wire logic clear_req,
  // Pins toward the device.
  output logic wake_pin,
  output logic chip_clear_pin_n
);
  initial begin
    wake_pin = 1'b1;
    chip_clear_pin_n = 1'b1;
  end
  // Levels move by non-blocking assignment on the rising edge, after the device has sampled.
  // A command set by the bench at a falling edge thus reaches the device one edge later.
  always @(posedge clk) begin
    wake_pin <= ~power_fail;
    chip_clear_pin_n <= ~clear_req;
  end
endmodule // hsc_pwr_model

// [testbench/test_halt_standby_control.sv]
`timescale 1ns/1ps
module test_halt_standby_control;
  import hsc_pkg::*;
  logic clk = 1'b0, nrst = 1'b1, rc = 1'b1, op_valid = 1'b0, mem_we = 1'b0;
  logic fail = 1'b0, clr = 1'b0, wake, clr_n, standby, strobe;
  logic [7:0] opcode = 8'h00;
  logic [5:0] mem_addr = 6'h00;
  logic [9:0] pc, p;
  logic [3:0] acc, rdata;
  logic [7:0] timer, t;
  int fail_count = 0, n_tests = 0;
  initial forever #4 clk = ~clk;
  hsc_pwr_model pwr_u (.clk(clk), .power_fail(fail), .clear_req(clr), .wake_pin(wake),
    .chip_clear_pin_n(clr_n));
  hsc_halt_standby_control dut_u (.clk(clk), .nrst(nrst), .chip_clear_pin_n(clr_n),
    .port_a({wake, 3'h0}), .osc_rc_option(rc), .opcode(opcode), .op_valid(op_valid),
    .mem_we(mem_we), .mem_addr(mem_addr), .standby_reg(standby), .program_counter_reg(pc),
    .acc_reg(acc), .timer_reg(timer), .exec_strobe_reg(strobe), .mem_rdata_reg(rdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic issue(input logic [7:0] o);
    opcode = o;
    op_valid = 1'b1;
    @(negedge clk);
  endtask
  task automatic idle(input int n);
    op_valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task automatic t_runs;
    p = pc;
    issue(8'hc5);
    chk(strobe, 1);
    chk(acc, 4'h5);
    issue(8'hc7);
    chk(strobe, 0);
    chk(acc, 4'h5);
    issue(8'hfc);
    chk(strobe, 1);
    chk(acc, 4'h0);
    issue(8'hfc);
    chk(strobe, 0);
    issue(8'hc9);
    chk(acc, 4'h9);
    chk(pc, p + 10'h005);
    issue(8'h93);
    chk(strobe, 0);
    issue(8'hd0);
    chk(strobe, 0);
    idle(1);
    $display("runs and absent opcodes done");
  endtask
  task automatic t_wake;
    fail = 1'b1;
    idle(2);
    issue(8'hf6);
    idle(2);
    chk(standby, 0);
    fail = 1'b0;
    issue(8'hc6);
    idle(1);
    mem_we = 1'b1;
    mem_addr = 6'h05;
    @(negedge clk);
    mem_we = 1'b0;
    // Idle cycles do not break a run, so this load is still a repeat.
    issue(8'hc3);
    chk(strobe, 0);
    chk(acc, 4'h6);
    issue(8'h00);
    issue(8'hc3);
    issue(8'hf6);
    idle(1);
    chk(standby, 1);
    p = pc;
    t = timer;
    // A write attempted in standby would overwrite the stored word with the new accumulator.
    mem_we = 1'b1;
    issue(8'hc5);
    idle(40);
    chk(pc, p);
    chk(acc, 4'h3);
    chk(timer, t);
    mem_we = 1'b0;
    fail = 1'b1;
    idle(3);
    chk(standby, 0);
    fail = 1'b0;
    idle(2);
    chk(rdata, 4'h6);
    issue(8'hc2);
    chk(strobe, 1);
    chk(pc, p + 10'h001);
    idle(1);
    $display("wake pin release done");
  endtask
  task automatic t_clear;
    rc = 1'b0;
    issue(8'hf6);
    idle(1);
    chk(standby, 1);
    fail = 1'b1;
    idle(4);
    chk(standby, 1);
    clr = 1'b1;
    idle(2);
    chk(standby, 0);
    chk(pc, HSC_PC_RESET);
    clr = 1'b0;
    fail = 1'b0;
    rc = 1'b1;
    idle(2);
    issue(8'hc4);
    issue(8'h00);
    idle(1);
    clr = 1'b1;
    idle(2);
    chk(pc, HSC_PC_RESET);
    chk(acc, 4'h0);
    chk(timer, 8'h00);
    chk(standby, 0);
    clr = 1'b0;
    // Sixteen running clocks after the release make one timer step, with margin either side.
    idle(18);
    chk(timer, 8'h01);
    $display("chip clear done");
  endtask
  task automatic report_and_stop;
    $display("tests=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    // Dropping reset just after time zero gives the asynchronous clear a real edge.
    #1 nrst = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    idle(1);
    chk(pc, HSC_PC_RESET);
    t_runs();
    t_wake();
    t_clear();
    report_and_stop();
  end
  // The whole sequence needs about 110 cycles; this leaves wide margin.
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule // test_halt_standby_control
